// ===== ext_int_pkg.sv
// Package for the external interrupt latch block.
// Assumes a single 40 MHz core clock and plain-port control bits.
package ext_int_pkg;

    // Trigger sensitivity of the external pin
    typedef enum logic {
        TRIG_EDGE_ONLY,
        TRIG_EDGE_LEVEL
    } trig_mode_t;

    // Software write strobes towards the status/control bits
    typedef struct packed {
        logic ack_wr;      // Write of one to the acknowledge bit
        logic mode_wr;     // Write strobe for the trigger-mode bit
        logic mode_val;    // Value written to the trigger-mode bit
        logic mask_wr;     // Write strobe for the disable bit
        logic mask_val;    // Value written to the disable bit
    } ctrl_wr_t;

    // Status/control readback image
    typedef struct packed {
        logic pending;     // Pending flag
        logic ack;         // Acknowledge bit, always zero
        logic disable_bit; // Interrupt disable bit
        logic mode;        // Trigger-mode bit
    } status_rd_t;

    // Reset values
    localparam logic MODE_RST = 1'b0;
    localparam logic MASK_RST = 1'b0;
    localparam logic LATCH_RST = 1'b0;
    localparam logic ACK_READ_VAL = 1'b0;
    localparam logic PIN_IDLE = 1'b1;

    // Clock rate and synchroniser depth
    localparam int CLK_HZ = 40_000_000;
    localparam int SYNC_STAGES = 2;

endpackage

// ===== ext_int_pin_sync.sv
// Two-flop synchroniser for the asynchronous active-low interrupt pin.
// Assumes the pin idles high; the first stage is read only by the second.
`timescale 1ns/100ps
`default_nettype none
module ext_int_pin_sync (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Pin in, synchronised level out
    input wire logic pin_n_in,
    output logic pin_n_sync_out
);
    import ext_int_pkg::*;

    logic meta_reg;

    // Both stages reset to the idle level so no false edge is seen
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_reg <= PIN_IDLE;
            pin_n_sync_out <= PIN_IDLE;
        end else begin
            meta_reg <= pin_n_in;
            pin_n_sync_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ===== external_interrupt_latch.sv
// External interrupt latch: active-low pin, edge or edge+level trigger.
// Assumes vector fetch, break state and break clear-enable arrive as
// same-clock signals from the CPU and system integration unit.
// Functional notes
// - A falling pin edge sets the request latch in either mode.
// - Vector fetch of this interrupt acknowledges and clears the latch.
// - Software writing one to acknowledge clears the latch.
// - Reset clears the latch and the trigger-mode bit.
// - Edge-only after reset; software may select edge plus level.
// - In edge-only mode, acknowledge clears the latch immediately.
// - In level mode, clear needs acknowledge and pin high, any order.
// - In level mode, pending and request stay while the pin is low.
// - Disable bit set blocks forwarding of the request to the CPU.
// - Pending flag shows latch state regardless of the disable bit.
// - Falling edges after a software acknowledge latch a new request.
// - Serviced request makes the CPU load PC from fixed vector pair.
// - CPU global interrupt mask also blocks the external request.
// - Pin level is readable by the CPU's pin branch instructions.
// - In break, software acknowledge clears only with clear-enable set.
// - Clear-enable at zero makes break-time acknowledge writes inert.
// - Acknowledge bit is write-only and reads as zero.
// - Disable bit is read/write, one disables, reset clears it.
// - Pending flag is read-only, one while a request is pending.
`timescale 1ns/100ps
`default_nettype none
module external_interrupt_latch (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // External active-low interrupt pin
    input wire logic ext_irq_n_in,
    // Software access to the status/control bits
    input wire ext_int_pkg::ctrl_wr_t ctrl_wr_in,
    output ext_int_pkg::status_rd_t ext_int_status_ctrl_out,
    // CPU side
    input wire logic vector_fetch_in,
    input wire logic ccr_int_mask_in,
    output logic cpu_irq_req_out,
    output logic pin_level_out,
    // Break control from the system integration unit
    input wire logic break_state_in,
    input wire logic break_clear_enable_in
);
    import ext_int_pkg::*;

    logic pin_n_sync;
    logic pin_n_prev_reg;
    localparam logic [1:0] ARM_CYCLES = 2'(SYNC_STAGES + 1);
    logic [1:0] arm_cnt_reg;
    logic edge_armed;
    logic fall_edge;
    logic sw_ack;
    logic any_ack;
    logic latch_reg;
    logic latch_next;
    logic ack_seen_reg;
    logic ack_seen_next;
    trig_mode_t mode_reg;
    logic ext_int_disable_bit_reg;

    // Pin synchroniser, the only reader of the raw pin
    ext_int_pin_sync i_ext_int_pin_sync (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .pin_n_in(ext_irq_n_in),
        .pin_n_sync_out(pin_n_sync)
    );

    // Previous synchronised level for edge detection
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_n_prev_reg <= PIN_IDLE;
        end else begin
            pin_n_prev_reg <= pin_n_sync;
        end
    end

    // Edge detection waits until the synchroniser and the previous-level
    // flop hold real pin samples. A pin held low through reset would
    // otherwise look like a fresh falling edge and re-latch. Limitation:
    // an edge in the first few cycles after reset is not seen.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            arm_cnt_reg <= 2'h0;
        end else if (arm_cnt_reg != ARM_CYCLES) begin
            arm_cnt_reg <= arm_cnt_reg + 2'h1;
        end
    end

    assign edge_armed = (arm_cnt_reg == ARM_CYCLES);

    // One-cycle falling edge; synchronised input gives one pulse per edge
    assign fall_edge = edge_armed & pin_n_prev_reg &
                       ~pin_n_sync;

    // Break-time software clears gated by the clear-enable bit
    assign sw_ack = ctrl_wr_in.ack_wr &
                    (~break_state_in | break_clear_enable_in);
    assign any_ack = sw_ack | vector_fetch_in;

    // Trigger-mode bit, edge-only out of reset
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_reg <= TRIG_EDGE_ONLY;
        end else if (ctrl_wr_in.mode_wr) begin
            mode_reg <= trig_mode_t'(ctrl_wr_in.mode_val);
        end
    end

    // Disable bit
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ext_int_disable_bit_reg <= MASK_RST;
        end else if (ctrl_wr_in.mask_wr) begin
            ext_int_disable_bit_reg <= ctrl_wr_in.mask_val;
        end
    end

    // Latch next state. In level mode an acknowledge is remembered until
    // the pin returns high, so the two conditions may come in any order.
    // A new edge always wins over a clear in the same cycle.
    always_comb begin
        latch_next = latch_reg;
        ack_seen_next = ack_seen_reg;
        if (mode_reg == TRIG_EDGE_ONLY) begin
            ack_seen_next = 1'b0;
            if (any_ack) begin
                latch_next = 1'b0;
            end
        end else begin
            if (any_ack && latch_reg) begin
                ack_seen_next = 1'b1;
            end
            if ((ack_seen_reg || any_ack) && pin_n_sync) begin
                latch_next = 1'b0;
                ack_seen_next = 1'b0;
            end
            if (!pin_n_sync && latch_reg) begin
                latch_next = 1'b1;
            end
        end
        if (fall_edge) begin
            latch_next = 1'b1;
            ack_seen_next = 1'b0; // A new request needs its own acknowledge
        end
    end

    // Request latch and remembered acknowledge
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            latch_reg <= LATCH_RST;
            ack_seen_reg <= 1'b0;
        end else begin
            latch_reg <= latch_next;
            ack_seen_reg <= ack_seen_next;
        end
    end

    // Request to the CPU: gated by the local and global masks. The CPU
    // then fetches the vector from the fixed pair, outside this block.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cpu_irq_req_out <= 1'b0;
        end else begin
            cpu_irq_req_out <= latch_next & ~ext_int_disable_bit_reg &
                               ~ccr_int_mask_in;
        end
    end

    // Readback image and pin level for the branch instructions
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ext_int_status_ctrl_out <= '{LATCH_RST, ACK_READ_VAL,
                                         MASK_RST, MODE_RST};
            pin_level_out <= PIN_IDLE;
        end else begin
            ext_int_status_ctrl_out.pending <= latch_next;
            ext_int_status_ctrl_out.ack <= ACK_READ_VAL;
            ext_int_status_ctrl_out.disable_bit <=
                ctrl_wr_in.mask_wr ? ctrl_wr_in.mask_val
                                   : ext_int_disable_bit_reg;
            ext_int_status_ctrl_out.mode <=
                ctrl_wr_in.mode_wr ? ctrl_wr_in.mode_val : mode_reg;
            pin_level_out <= pin_n_sync;
        end
    end

    // Checks
    property p_edge_sets;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        fall_edge |=> latch_reg;
    endproperty
    a_edge_sets: assert property (p_edge_sets)
        else $error("falling edge did not set latch");

    property p_edge_mode_clear;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (mode_reg == TRIG_EDGE_ONLY && any_ack && !fall_edge) |=> !latch_reg;
    endproperty
    a_edge_mode_clear: assert property (p_edge_mode_clear)
        else $error("edge mode acknowledge did not clear latch");

    property p_level_hold;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (mode_reg == TRIG_EDGE_LEVEL && latch_reg && !pin_n_sync)
            |=> latch_reg;
    endproperty
    a_level_hold: assert property (p_level_hold)
        else $error("level mode latch dropped while pin low");

    property p_level_clear;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (mode_reg == TRIG_EDGE_LEVEL && any_ack && pin_n_sync && !fall_edge)
            |=> !latch_reg;
    endproperty
    a_level_clear: assert property (p_level_clear)
        else $error("level mode clear with pin high failed");

    property p_break_protect;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (break_state_in && !break_clear_enable_in && latch_reg &&
         !vector_fetch_in && !ack_seen_reg) |=> latch_reg;
    endproperty
    a_break_protect: assert property (p_break_protect)
        else $error("latch cleared during protected break");

    property p_mask_blocks;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (ext_int_disable_bit_reg || ccr_int_mask_in) |=> !cpu_irq_req_out;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks)
        else $error("masked request forwarded");

    property p_pending_tracks;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        ##1 ext_int_status_ctrl_out.pending == latch_reg;
    endproperty
    a_pending_tracks: assert property (p_pending_tracks)
        else $error("pending flag differs from latch");

    property p_ack_reads_zero;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        ctrl_wr_in.ack_wr |=> !ext_int_status_ctrl_out.ack;
    endproperty
    a_ack_reads_zero: assert property (p_ack_reads_zero)
        else $error("acknowledge bit read back nonzero");

    property p_sw_clear;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (ctrl_wr_in.ack_wr && !break_state_in && pin_n_sync && !fall_edge)
            |=> !latch_reg;
    endproperty
    a_sw_clear: assert property (p_sw_clear)
        else $error("software acknowledge did not clear latch");

    property p_break_sw_clear;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (break_state_in && break_clear_enable_in && ctrl_wr_in.ack_wr &&
         pin_n_sync && !fall_edge) |=> !latch_reg;
    endproperty
    a_break_sw_clear: assert property (p_break_sw_clear)
        else $error("enabled break acknowledge did not clear latch");

    property p_edge_single;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        fall_edge |=> !fall_edge;
    endproperty
    a_edge_single: assert property (p_edge_single)
        else $error("one pin transition gave two edge pulses");

    property p_unmasked_forwards;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (!ext_int_disable_bit_reg && !ccr_int_mask_in)
            |=> (cpu_irq_req_out == latch_reg);
    endproperty
    a_unmasked_forwards: assert property (p_unmasked_forwards)
        else $error("unmasked request not forwarded");

    property p_disable_readback;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        ctrl_wr_in.mask_wr |=>
            (ext_int_disable_bit_reg == $past(ctrl_wr_in.mask_val)) &&
            (ext_int_status_ctrl_out.disable_bit == ext_int_disable_bit_reg);
    endproperty
    a_disable_readback: assert property (p_disable_readback)
        else $error("disable bit did not take the written value");

    property p_mode_readback;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        ctrl_wr_in.mode_wr |=>
            (ext_int_status_ctrl_out.mode == $past(ctrl_wr_in.mode_val));
    endproperty
    a_mode_readback: assert property (p_mode_readback)
        else $error("trigger-mode bit did not take the written value");

    property p_pending_masked;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (ext_int_disable_bit_reg && fall_edge)
            |=> ext_int_status_ctrl_out.pending;
    endproperty
    a_pending_masked: assert property (p_pending_masked)
        else $error("masked edge not shown as pending");

    property p_pin_level;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        pin_level_out == $past(pin_n_sync);
    endproperty
    a_pin_level: assert property (p_pin_level)
        else $error("pin level output does not follow the pin");
endmodule
`default_nettype wire

// ===== ext_irq_source.sv
// Behavioural source that drives the active-low external interrupt pin.
// Assumes the bench commands the level; a released pin idles high.
`timescale 1ns/100ps
`default_nettype none
module ext_irq_source (
    // Command from the bench
    input wire logic hold_low_in,
    // Active-low pin
    output logic irq_n_out
);
    // Released pin sits at the pull-up level; the skew keeps pin
    // transitions away from the sampling edge of the core clock
    assign #3 irq_n_out = hold_low_in ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ===== external_interrupt_latch_tb_top.sv
// Bench for the external interrupt latch: edge, level, mask and break.
// Assumes the package and the pin source model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module external_interrupt_latch_tb_top;
    import ext_int_pkg::*;
    localparam ctrl_wr_t NONE = '0;
    localparam ctrl_wr_t ACK_WR = '{ack_wr: 1'b1, default: 1'b0};
    localparam ctrl_wr_t MASK_ON = '{mask_wr: 1'b1, mask_val: 1'b1,
                                     default: 1'b0};
    localparam ctrl_wr_t MASK_OFF = '{mask_wr: 1'b1, default: 1'b0};
    localparam ctrl_wr_t LEVEL = '{mode_wr: 1'b1, mode_val: 1'b1,
                                   default: 1'b0};
    logic core_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic hold_low = 1'b0;
    logic irq_n;
    ctrl_wr_t ctrl = '0;
    status_rd_t st;
    logic vfetch = 1'b0;
    logic ccr_mask = 1'b0;
    logic irq_req;
    logic pin_lvl;
    logic brk = 1'b0;
    logic brk_clr = 1'b0;
    int fails = 0;
    int checked = 0;

    // 40 MHz core clock
    always #12.5 core_clk_in = ~core_clk_in;

    ext_irq_source i_ext_irq_source (.hold_low_in(hold_low),
        .irq_n_out(irq_n));

    external_interrupt_latch i_external_interrupt_latch (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .ext_irq_n_in(irq_n), .ctrl_wr_in(ctrl),
        .ext_int_status_ctrl_out(st), .vector_fetch_in(vfetch),
        .ccr_int_mask_in(ccr_mask), .cpu_irq_req_out(irq_req),
        .pin_level_out(pin_lvl), .break_state_in(brk),
        .break_clear_enable_in(brk_clr));

    // Verdict and end of run, shared by the timeout path
    task automatic end_sim();
        if (fails == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic seen, input logic exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %b seen %b", name, exp, seen);
        end
    endtask

    task automatic nxt(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask

    // Outputs are sampled mid-cycle, well clear of the launching edge
    task automatic mid();
        @(negedge core_clk_in);
    endtask

    // One-cycle strobe pulse, as the control port expects
    task automatic wr(input ctrl_wr_t v, input logic vf);
        @(posedge core_clk_in);
        ctrl <= v;
        vfetch <= vf;
        @(posedge core_clk_in);
        ctrl <= NONE;
        vfetch <= 1'b0;
    endtask

    task automatic pin(input logic low);
        @(posedge core_clk_in);
        hold_low <= low;
    endtask

    // Synchroniser latency varies with pin skew, so wait with a bound
    task automatic wait_pend(input logic exp);
        int n = 0;
        mid();
        while (st.pending !== exp) begin
            @(negedge core_clk_in);
            n++;
            if (n > 8) begin
                fails++;
                $display("unexpected pending wait: expected %b seen %b",
                         exp, st.pending);
                end_sim();
            end
        end
    endtask

    // Main sequence: reset, edge, mask, level, break, reset while low
    initial begin
        nxt(4);
        rst_n_in <= 1'b1;
        mid();
        chk("pending", st.pending, LATCH_RST);
        chk("ack", st.ack, ACK_READ_VAL);
        chk("disable", st.disable_bit, MASK_RST);
        chk("mode", st.mode, MODE_RST);
        chk("irq", irq_req, 1'b0);
        chk("pin level", pin_lvl, PIN_IDLE);
        pin(1'b1);
        wait_pend(1'b1);
        nxt(2);
        mid();
        chk("irq", irq_req, 1'b1);
        chk("pin level", pin_lvl, 1'b0);
        wr(ACK_WR, 1'b0);
        nxt(4);
        mid();
        chk("pending", st.pending, 1'b0);
        chk("ack", st.ack, ACK_READ_VAL);
        pin(1'b0);
        nxt(4);
        pin(1'b1);
        wait_pend(1'b1);
        wr(NONE, 1'b1);
        nxt(1);
        mid();
        chk("pending", st.pending, 1'b0);
        pin(1'b0);
        wr(MASK_ON, 1'b0);
        pin(1'b1);
        wait_pend(1'b1);
        chk("disable", st.disable_bit, 1'b1);
        chk("irq", irq_req, 1'b0);
        wr(MASK_OFF, 1'b0);
        nxt(2);
        mid();
        chk("irq", irq_req, 1'b1);
        @(posedge core_clk_in);
        ccr_mask <= 1'b1;
        nxt(2);
        mid();
        chk("irq", irq_req, 1'b0);
        @(posedge core_clk_in);
        ccr_mask <= 1'b0;
        wr(ACK_WR, 1'b0);
        pin(1'b0);
        wr(LEVEL, 1'b0);
        mid();
        chk("mode", st.mode, 1'b1);
        pin(1'b1);
        wait_pend(1'b1);
        wr(ACK_WR, 1'b0);
        nxt(4);
        mid();
        chk("pending", st.pending, 1'b1);
        chk("irq", irq_req, 1'b1);
        wr(MASK_ON, 1'b0);
        nxt(1);
        mid();
        chk("irq", irq_req, 1'b0);
        pin(1'b0);
        wait_pend(1'b0);
        wr(MASK_OFF, 1'b0);
        pin(1'b1);
        wait_pend(1'b1);
        pin(1'b0);
        nxt(5);
        mid();
        chk("pending", st.pending, 1'b1);
        wr(NONE, 1'b1);
        nxt(1);
        mid();
        chk("pending", st.pending, 1'b0);
        @(posedge core_clk_in);
        brk <= 1'b1;
        pin(1'b1);
        wait_pend(1'b1);
        pin(1'b0);
        nxt(5);
        wr(ACK_WR, 1'b0);
        nxt(3);
        mid();
        chk("pending", st.pending, 1'b1);
        @(posedge core_clk_in);
        brk_clr <= 1'b1;
        wr(ACK_WR, 1'b0);
        nxt(1);
        mid();
        chk("pending", st.pending, 1'b0);
        @(posedge core_clk_in);
        brk <= 1'b0;
        brk_clr <= 1'b0;
        nxt(3);
        mid();
        chk("pending", st.pending, 1'b0);
        pin(1'b1);
        wait_pend(1'b1);
        @(posedge core_clk_in);
        rst_n_in <= 1'b0;
        nxt(2);
        mid();
        chk("pending", st.pending, 1'b0);
        chk("mode", st.mode, 1'b0);
        chk("irq", irq_req, 1'b0);
        @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        nxt(4);
        mid();
        chk("pending", st.pending, 1'b0);
        end_sim();
    end
endmodule
`default_nettype wire
